// *** core/tpo_pkg.sv ***
/*
 * Shared constants of the touch and proximity option decoder: bank offsets,
 * field positions, decode tables and timing figures.
 * Assumes a 100 MHz system clock and 8-bit register addresses.
 */
package tpo_pkg;
	localparam logic [7:0] TPO_OFS_BANK0 = 8'hc4;
	localparam logic [7:0] TPO_OFS_BANK1 = 8'hc5;
	localparam logic [7:0] TPO_OFS_BANK2 = 8'hc6;
	localparam logic [7:0] TPO_OFS_STATUS = 8'hc7;
	localparam logic [7:0] TPO_BANK_RESET = 8'h00;
	// Bank 0 fields
	localparam int TPO_B0_TOUCH_OUTPUT_FUNCTION = 7;
	localparam int TPO_B0_PROXIMITY_OUTPUT_FUNCTION = 6;
	localparam int TPO_B0_POL = 5;
	localparam int TPO_B0_TOUCH_THRESHOLD_SELECT_LSB = 2;
	localparam int TPO_B0_PROXIMITY_THRESHOLD_SELECT_LSB = 0;
	// Bank 1 fields
	localparam int TPO_B1_HALT_LSB = 6;
	localparam int TPO_B1_BASE_LSB = 0;
	localparam logic [7:0] TPO_B1_READ_MASK = 8'hc7;
	// Bank 2 fields
	localparam int TPO_B2_STREAM = 7;
	localparam int TPO_B2_CHARGE_TRANSFER_FREQUENCY = 6;
	localparam int TPO_B2_STREAMING_ENABLE = 5;
	localparam int TPO_B2_TARGET = 3;
	localparam int TPO_B2_TUNE = 2;
	localparam int TPO_B2_LP_LSB = 0;
	localparam logic [7:0] TPO_B2_READ_MASK = 8'hef;
	// Decoded values
	localparam logic [9:0] TPO_FREQ_FAST_KHZ = 10'h200;
	localparam logic [9:0] TPO_FREQ_SLOW_KHZ = 10'h0fa;
	localparam logic [10:0] TPO_TARGET_HIGH = 11'h400;
	localparam logic [10:0] TPO_TARGET_LOW = 11'h200;
	localparam logic [7:0] TPO_HALT_SHORT_S = 8'h14;
	localparam logic [7:0] TPO_HALT_LONG_S = 8'h28;
	localparam logic [7:0] TPO_HALT_NONE_S = 8'h00;
	// Event qualification in consecutive samples
	localparam int TPO_PROX_SAMPLES = 6;
	localparam int TPO_TOUCH_SAMPLES = 3;
	// Latch hold time
	localparam int TPO_CLK_MHZ = 100;
	localparam int TPO_LATCH_MS = 4000;
	localparam int TPO_LATCH_CYCLES = TPO_LATCH_MS * 1000 * TPO_CLK_MHZ;
	// Cycles after reset release in which the programmer may fill the banks
	localparam int TPO_PROG_WINDOW = 16;

	typedef enum logic [1:0] {
		TPO_BOOST_POWER = 2'b00,
		TPO_NORMAL_POWER = 2'b01,
		TPO_LOW_POWER_ONE = 2'b10,
		TPO_LOW_POWER_TWO = 2'b11
	} tpo_power_t;

	// Touch threshold numerator over 256
	function automatic logic [7:0] tpo_touch_frac(input logic [2:0] sel);
		case (sel)
			3'h0: tpo_touch_frac = 8'h48;
			3'h1: tpo_touch_frac = 8'h08;
			3'h2: tpo_touch_frac = 8'h18;
			3'h3: tpo_touch_frac = 8'h30;
			3'h4: tpo_touch_frac = 8'h60;
			3'h5: tpo_touch_frac = 8'h80;
			3'h6: tpo_touch_frac = 8'ha0;
			default: tpo_touch_frac = 8'hc0;
		endcase
	endfunction : tpo_touch_frac

	function automatic logic [4:0] tpo_prox_thr(input logic [1:0] sel);
		case (sel)
			2'h0: tpo_prox_thr = 5'h04;
			2'h1: tpo_prox_thr = 5'h02;
			2'h2: tpo_prox_thr = 5'h08;
			default: tpo_prox_thr = 5'h10;
		endcase
	endfunction : tpo_prox_thr

	function automatic logic [9:0] tpo_scan_ms(input logic [1:0] sel);
		case (sel)
			2'h0: tpo_scan_ms = 10'h009;
			2'h1: tpo_scan_ms = 10'h080;
			2'h2: tpo_scan_ms = 10'h100;
			default: tpo_scan_ms = 10'h200;
		endcase
	endfunction : tpo_scan_ms

	function automatic logic [8:0] tpo_base(input logic [2:0] sel);
		case (sel)
			3'h0: tpo_base = 9'h0c8;
			3'h1: tpo_base = 9'h032;
			3'h2: tpo_base = 9'h04b;
			3'h3: tpo_base = 9'h064;
			3'h4: tpo_base = 9'h096;
			3'h5: tpo_base = 9'h0fa;
			3'h6: tpo_base = 9'h12c;
			default: tpo_base = 9'h1f4;
		endcase
	endfunction : tpo_base
endpackage : tpo_pkg

// *** core/tpo_option_decoder.sv ***
/*
 * Touch and proximity option decoder: three write-once option banks, their
 * decode into working settings, and the touch and proximity output pins.
 * Assumes the bank programmer and the measurement logic sit on clk_in.
 */
`timescale 1ns/1ps
`default_nettype none
module tpo_option_decoder
	import tpo_pkg::*;
#(
	parameter int CW = 16,
	parameter int LATCH_CYCLES = TPO_LATCH_CYCLES
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	input wire logic sample_valid_in,
	input wire logic [CW-1:0] long_term_average_in,
	input wire logic [CW-1:0] count_in,
	output logic touch_output_pin_out,
	output logic proximity_output_pin_out,
	output logic config_loaded_out,
	output logic [7:0] touch_fraction_out,
	output logic [4:0] proximity_threshold_out,
	output logic halt_valid_out,
	output logic [1:0] recalibration_halt_time_out,
	output logic [7:0] halt_seconds_out,
	output logic [8:0] base_value_out,
	output logic stream_two_wire_out,
	output logic streaming_enable_out,
	output logic [9:0] charge_transfer_frequency_out,
	output logic [10:0] tuning_target_out,
	output logic automatic_tuning_partial_out,
	output logic [1:0] power_mode_select_out,
	output logic [9:0] scan_period_ms_out
);
	if (CW < 9 || CW > 24) begin : g_bad_cw
		$error("CW out of range");
	end
	if (LATCH_CYCLES < 2) begin : g_bad_latch
		$error("LATCH_CYCLES too small");
	end
	if (TPO_PROG_WINDOW < 2 || TPO_PROG_WINDOW > 256) begin : g_bad_window
		$error("TPO_PROG_WINDOW out of range");
	end

	typedef struct packed {
		logic [2:0][7:0] bank;
		logic [2:0] programmed;
		logic loaded;
		logic [7:0] prog_wait;
		logic [7:0] rdata;
		// Decoded settings, frozen once loaded
		logic touch_toggle;
		logic prox_latch;
		logic active_high;
		logic [7:0] touch_frac;
		logic [4:0] prox_thr;
		logic halt_valid;
		logic [1:0] halt_sel;
		logic [7:0] halt_s;
		logic [8:0] base;
		logic two_wire;
		logic stream_en;
		logic [9:0] freq_khz;
		logic [10:0] target;
		logic partial;
		tpo_power_t power;
		logic [9:0] scan_ms;
		// Event tracking
		logic [2:0] prox_cnt;
		logic [2:0] touch_cnt;
		logic prox_act;
		logic touch_act;
		logic touch_state;
		logic prox_state;
		logic [31:0] latch_timer;
		logic touch_pin;
		logic prox_pin;
	} tpo_state_t;

	tpo_state_t st_r;
	tpo_state_t st_nxt;

	// Clamped difference between average and current count
	function automatic logic [CW-1:0] drop_of(input logic [CW-1:0] long_term_average, input logic [CW-1:0] cs);
		drop_of = (long_term_average > cs) ? long_term_average - cs : '0;
	endfunction : drop_of

	logic [CW-1:0] drop;
	logic [CW+7:0] touch_prod;
	logic [CW-1:0] touch_thr;
	logic prox_hit;
	logic touch_hit;
	logic bank_sel;
	logic [1:0] bank_idx;

	always_comb begin
		drop = drop_of(long_term_average_in, count_in);
		touch_prod = long_term_average_in * st_r.touch_frac;
		touch_thr = touch_prod[CW+7:8];
		prox_hit = drop >= CW'(st_r.prox_thr);
		touch_hit = drop >= touch_thr;
		bank_sel = 1'b1;
		bank_idx = 2'h0;
		case (reg_addr_in)
			TPO_OFS_BANK0: bank_idx = 2'h0;
			TPO_OFS_BANK1: bank_idx = 2'h1;
			TPO_OFS_BANK2: bank_idx = 2'h2;
			default: bank_sel = 1'b0;
		endcase
	end

	always_comb begin
		st_nxt = st_r;

		// Each bank takes one write only, like the fuses it models
		if (reg_wr_in && bank_sel && !st_r.programmed[bank_idx]) begin
			st_nxt.bank[bank_idx] = reg_wdata_in;
			st_nxt.programmed[bank_idx] = 1'b1;
		end

		// Reads answer one cycle later; unmapped addresses read zero
		st_nxt.rdata = 8'h00;
		if (reg_rd_in) begin
			case (reg_addr_in)
				TPO_OFS_BANK0: st_nxt.rdata = st_r.bank[0];
				TPO_OFS_BANK1: st_nxt.rdata = st_r.bank[1] & TPO_B1_READ_MASK;
				TPO_OFS_BANK2: st_nxt.rdata = st_r.bank[2] & TPO_B2_READ_MASK;
				TPO_OFS_STATUS: st_nxt.rdata = {st_r.prox_state, st_r.touch_state,
					st_r.prox_act, st_r.touch_act, st_r.loaded, st_r.programmed};
				default: st_nxt.rdata = 8'h00;
			endcase
		end

		// Banks written inside the window after reset are decoded once;
		// a write at or after the decode edge is never decoded; the next reset clears it
		if (!st_r.loaded && st_r.prog_wait != 8'(TPO_PROG_WINDOW - 1))
			st_nxt.prog_wait = st_r.prog_wait + 8'h01;
		if (!st_r.loaded && st_r.prog_wait == 8'(TPO_PROG_WINDOW - 1)) begin
			st_nxt.loaded = 1'b1;
			st_nxt.touch_toggle = st_r.bank[0][TPO_B0_TOUCH_OUTPUT_FUNCTION];
			st_nxt.prox_latch = st_r.bank[0][TPO_B0_PROXIMITY_OUTPUT_FUNCTION];
			st_nxt.active_high = st_r.bank[0][TPO_B0_POL];
			st_nxt.touch_frac = tpo_touch_frac(st_r.bank[0][TPO_B0_TOUCH_THRESHOLD_SELECT_LSB +: 3]);
			st_nxt.prox_thr = tpo_prox_thr(st_r.bank[0][TPO_B0_PROXIMITY_THRESHOLD_SELECT_LSB +: 2]);
			st_nxt.two_wire = st_r.bank[2][TPO_B2_STREAM];
			st_nxt.freq_khz = st_r.bank[2][TPO_B2_CHARGE_TRANSFER_FREQUENCY] ? TPO_FREQ_SLOW_KHZ
				: TPO_FREQ_FAST_KHZ;
			st_nxt.stream_en = st_r.bank[2][TPO_B2_STREAMING_ENABLE];
			st_nxt.target = st_r.bank[2][TPO_B2_TARGET] ? TPO_TARGET_LOW
				: TPO_TARGET_HIGH;
			st_nxt.partial = st_r.bank[2][TPO_B2_TUNE];
			st_nxt.power = tpo_power_t'(st_r.bank[2][TPO_B2_LP_LSB +: 2]);
			st_nxt.scan_ms = tpo_scan_ms(st_r.bank[2][TPO_B2_LP_LSB +: 2]);
			// Bank 1 layout is meaningless under partial tuning
			st_nxt.halt_valid = !st_r.bank[2][TPO_B2_TUNE];
			st_nxt.halt_sel = 2'h0;
			st_nxt.halt_s = TPO_HALT_NONE_S;
			st_nxt.base = '0;
			if (!st_r.bank[2][TPO_B2_TUNE]) begin
				st_nxt.halt_sel = st_r.bank[1][TPO_B1_HALT_LSB +: 2];
				case (st_r.bank[1][TPO_B1_HALT_LSB +: 2])
					2'h0: st_nxt.halt_s = TPO_HALT_SHORT_S;
					2'h1: st_nxt.halt_s = TPO_HALT_LONG_S;
					2'h2: st_nxt.halt_s = TPO_HALT_NONE_S;
					default: st_nxt.halt_s = TPO_HALT_LONG_S;
				endcase
				st_nxt.base = tpo_base(st_r.bank[1][TPO_B1_BASE_LSB +: 3]);
			end
		end

		// Consecutive-sample qualification, only once settings are live
		if (st_r.loaded && sample_valid_in) begin
			if (prox_hit) begin
				if (st_r.prox_cnt < 3'(TPO_PROX_SAMPLES))
					st_nxt.prox_cnt = st_r.prox_cnt + 3'h1;
			end else begin
				st_nxt.prox_cnt = 3'h0;
			end
			if (touch_hit) begin
				if (st_r.touch_cnt < 3'(TPO_TOUCH_SAMPLES))
					st_nxt.touch_cnt = st_r.touch_cnt + 3'h1;
			end else begin
				st_nxt.touch_cnt = 3'h0;
			end
		end
		st_nxt.prox_act = st_nxt.prox_cnt == 3'(TPO_PROX_SAMPLES);
		st_nxt.touch_act = st_nxt.touch_cnt == 3'(TPO_TOUCH_SAMPLES);

		// Touch output: follow the event, or invert on each new one
		if (st_r.touch_toggle) begin
			if (st_nxt.touch_act && !st_r.touch_act)
				st_nxt.touch_state = !st_r.touch_state;
		end else begin
			st_nxt.touch_state = st_nxt.touch_act;
		end

		// Proximity output: follow the event, or hold for the latch time
		if (st_r.latch_timer != 32'h0000_0000)
			st_nxt.latch_timer = st_r.latch_timer - 32'h0000_0001;
		if (st_r.prox_latch) begin
			if (st_nxt.prox_act && !st_r.prox_act)
				st_nxt.latch_timer = 32'(LATCH_CYCLES);
			st_nxt.prox_state = st_nxt.prox_act
				|| st_nxt.latch_timer != 32'h0000_0000;
		end else begin
			st_nxt.prox_state = st_nxt.prox_act;
		end

		// Push-pull pins; inactive level follows the polarity choice
		st_nxt.touch_pin = st_nxt.active_high ? st_nxt.touch_state : !st_nxt.touch_state;
		st_nxt.prox_pin = st_nxt.active_high ? st_nxt.prox_state : !st_nxt.prox_state;
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			st_r <= '0;
			st_r.bank <= {3{TPO_BANK_RESET}};
			st_r.touch_pin <= 1'b1;
			st_r.prox_pin <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	always_comb begin
		reg_rdata_out = st_r.rdata;
		touch_output_pin_out = st_r.touch_pin;
		proximity_output_pin_out = st_r.prox_pin;
		config_loaded_out = st_r.loaded;
		touch_fraction_out = st_r.touch_frac;
		proximity_threshold_out = st_r.prox_thr;
		halt_valid_out = st_r.halt_valid;
		recalibration_halt_time_out = st_r.halt_sel;
		halt_seconds_out = st_r.halt_s;
		base_value_out = st_r.base;
		stream_two_wire_out = st_r.two_wire;
		streaming_enable_out = st_r.stream_en;
		charge_transfer_frequency_out = st_r.freq_khz;
		tuning_target_out = st_r.target;
		automatic_tuning_partial_out = st_r.partial;
		power_mode_select_out = st_r.power;
		scan_period_ms_out = st_r.scan_ms;
	end

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);

	sequence s_touch_new;
		st_r.touch_toggle && !st_r.touch_act ##1 st_r.touch_act;
	endsequence

	property p_touch_toggle;
		logic prev;
		(1, prev = st_r.touch_state) ##0 s_touch_new |-> st_r.touch_state != prev;
	endproperty
	a_touch_toggle: assert property (p_touch_toggle) else $error("toggle missed");

	property p_prox_latch_start;
		st_r.prox_latch && $rose(st_r.prox_act)
			|-> st_r.latch_timer == 32'(LATCH_CYCLES) && st_r.prox_state;
	endproperty
	a_prox_latch_start: assert property (p_prox_latch_start) else $error("latch not armed");

	property p_prox_latch_hold;
		st_r.prox_latch && st_r.latch_timer > 32'h0000_0001 |=> st_r.prox_state;
	endproperty
	a_prox_latch_hold: assert property (p_prox_latch_hold) else $error("latch dropped");

	property p_prox_six;
		$rose(st_r.prox_act) |-> $past(st_r.prox_cnt) == 3'(TPO_PROX_SAMPLES - 1)
			&& $past(sample_valid_in) && $past(prox_hit);
	endproperty
	a_prox_six: assert property (p_prox_six) else $error("early proximity");

	property p_polarity;
		st_r.loaded |-> proximity_output_pin_out == (st_r.active_high ~^ st_r.prox_state);
	endproperty
	a_polarity: assert property (p_polarity) else $error("pin polarity wrong");

	property p_frozen;
		st_r.loaded |=> $stable(scan_period_ms_out) && $stable(touch_fraction_out)
			&& $stable(tuning_target_out);
	endproperty
	a_frozen: assert property (p_frozen) else $error("settings changed");

	property p_write_once;
		reg_wr_in && reg_addr_in == TPO_OFS_BANK0 && st_r.programmed[0]
			|=> $stable(st_r.bank[0]);
	endproperty
	a_write_once: assert property (p_write_once) else $error("bank rewritten");

	property p_halt_partial;
		st_r.loaded && st_r.partial |-> !halt_valid_out && halt_seconds_out == TPO_HALT_NONE_S;
	endproperty
	a_halt_partial: assert property (p_halt_partial) else $error("halt under partial");

	property p_read_bank2;
		reg_rd_in && reg_addr_in == TPO_OFS_BANK2
			|=> reg_rdata_out == ($past(st_r.bank[2]) & TPO_B2_READ_MASK);
	endproperty
	a_read_bank2: assert property (p_read_bank2) else $error("bank read wrong");

	property p_scan_table;
		$rose(st_r.loaded) |-> scan_period_ms_out == tpo_scan_ms($past(st_r.bank[2][1:0]));
	endproperty
	a_scan_table: assert property (p_scan_table) else $error("scan period wrong");

	property p_decode_bank0;
		$rose(st_r.loaded) |-> touch_fraction_out
			== tpo_touch_frac($past(st_r.bank[0][TPO_B0_TOUCH_THRESHOLD_SELECT_LSB +: 3]));
	endproperty
	a_decode_bank0: assert property (p_decode_bank0) else $error("touch threshold wrong");

	property p_load_time;
		$rose(st_r.loaded) |-> $past(st_r.prog_wait) == 8'(TPO_PROG_WINDOW - 1);
	endproperty
	a_load_time: assert property (p_load_time) else $error("decode outside window");
endmodule : tpo_option_decoder
`default_nettype wire

// *** dv/tpo_prog_model.sv ***
/*
 * Bank programmer model: writes and reads option bytes over the plain
 * register port. Assumes clk_in is the decoder clock, read data one cycle late.
 */
`timescale 1ns/1ps
`default_nettype none
module tpo_prog_model (
	input wire logic clk_in,
	input wire logic [7:0] reg_rdata_in,
	output logic [7:0] reg_addr_out,
	output logic [7:0] reg_wdata_out,
	output logic reg_wr_out,
	output logic reg_rd_out
);
	initial begin
		reg_addr_out = 8'h00;
		reg_wdata_out = 8'h00;
		reg_wr_out = 1'b0;
		reg_rd_out = 1'b0;
	end

	// Idle bus shows the inverse, so stale values never pass as fresh
	task automatic write_byte(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk_in);
		reg_wr_out <= 1'b1;
		reg_addr_out <= addr;
		reg_wdata_out <= data;
		@(posedge clk_in);
		reg_wr_out <= 1'b0;
		reg_addr_out <= ~addr;
		reg_wdata_out <= ~data;
	endtask : write_byte

	task automatic read_byte(input logic [7:0] addr, output logic [7:0] data);
		@(posedge clk_in);
		reg_rd_out <= 1'b1;
		reg_addr_out <= addr;
		@(posedge clk_in);
		reg_rd_out <= 1'b0;
		reg_addr_out <= ~addr;
		#1;
		data = reg_rdata_in;
	endtask : read_byte
endmodule : tpo_prog_model
`default_nettype wire

// *** dv/tpo_option_decoder_tb_top.sv ***
/*
 * Self-checking bench of the option decoder: defaults, bank access, sensing,
 * and banks programmed inside the window after reset.
 * Assumes the programmer model file is compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tpo_option_decoder_tb_top import tpo_pkg::*; ;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic sample_valid = 1'b0;
	logic [15:0] long_term_average = 16'h0000;
	logic [15:0] cs = 16'h0000;
	logic [7:0] addr, wdata, rdata, rv, tfrac, halt_s;
	logic wr, rd, tpin, ppin, loaded, hvalid, two_wire, stream_en, partial;
	logic [4:0] proximity_threshold_select;
	logic [1:0] hcode, pmode;
	logic [8:0] base;
	logic [9:0] freq, scan;
	logic [10:0] target;
	int fail_count = 0;
	int checks_done = 0;

	always #5 clk_in = ~clk_in;

	tpo_prog_model prog_u (.clk_in(clk_in), .reg_rdata_in(rdata), .reg_addr_out(addr),
		.reg_wdata_out(wdata), .reg_wr_out(wr), .reg_rd_out(rd));

	tpo_option_decoder #(.CW(16), .LATCH_CYCLES(20)) dut_u (.clk_in(clk_in),
		.sys_rst_in(sys_rst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.sample_valid_in(sample_valid), .long_term_average_in(long_term_average), .count_in(cs),
		.touch_output_pin_out(tpin), .proximity_output_pin_out(ppin),
		.config_loaded_out(loaded), .touch_fraction_out(tfrac),
		.proximity_threshold_out(proximity_threshold_select), .halt_valid_out(hvalid),
		.recalibration_halt_time_out(hcode), .halt_seconds_out(halt_s),
		.base_value_out(base), .stream_two_wire_out(two_wire),
		.streaming_enable_out(stream_en), .charge_transfer_frequency_out(freq),
		.tuning_target_out(target), .automatic_tuning_partial_out(partial),
		.power_mode_select_out(pmode), .scan_period_ms_out(scan));

	task automatic tally_and_finish();
		$display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	task automatic do_reset();
		@(posedge clk_in);
		sys_rst_in <= 1'b1;
		repeat (5) @(posedge clk_in);
		#1;
		`CHK(ppin, 1'b1)
		`CHK(loaded, 1'b0)
		@(posedge clk_in);
		sys_rst_in <= 1'b0;
	endtask : do_reset

	// Decode lands one programming window after reset release
	task automatic wait_loaded();
		int n;
		for (n = 0; n < 40 && loaded !== 1'b1; n++) begin
			@(posedge clk_in);
			#1;
		end
		if (n == 40) begin
			fail_count++;
			tally_and_finish();
		end
		`CHK(loaded, 1'b1)
	endtask : wait_loaded

	task automatic program_banks(input logic [7:0] b0, input logic [7:0] b1,
		input logic [7:0] b2);
		do_reset();
		prog_u.write_byte(TPO_OFS_BANK0, b0);
		prog_u.write_byte(TPO_OFS_BANK1, b1);
		prog_u.write_byte(TPO_OFS_BANK2, b2);
		wait_loaded();
	endtask : program_banks

	// Unprogrammed banks decode to every field's zero setting
	task automatic t_defaults();
		`CHK(tpin, 1'b1)
		`CHK(tfrac, 8'h48)
		`CHK(proximity_threshold_select, 5'h04)
		`CHK(hvalid, 1'b1)
		`CHK(hcode, 2'h0)
		`CHK(halt_s, 8'h14)
		`CHK(base, 9'h0c8)
		`CHK(two_wire, 1'b0)
		`CHK(freq, 10'h200)
		`CHK(stream_en, 1'b0)
		`CHK(target, 11'h400)
		`CHK(partial, 1'b0)
		`CHK(pmode, 2'h0)
		`CHK(scan, 10'h009)
	endtask : t_defaults

	task automatic t_regs();
		prog_u.write_byte(TPO_OFS_BANK0, 8'ha5);
		prog_u.write_byte(TPO_OFS_BANK1, 8'hff);
		prog_u.write_byte(TPO_OFS_BANK2, 8'hff);
		prog_u.write_byte(TPO_OFS_BANK0, 8'h3c);
		prog_u.write_byte(TPO_OFS_STATUS, 8'hf0);
		prog_u.read_byte(TPO_OFS_BANK0, rv);
		`CHK(rv, 8'ha5)
		@(posedge clk_in);
		#1;
		`CHK(rdata, 8'h00)
		prog_u.read_byte(TPO_OFS_BANK1, rv);
		`CHK(rv, 8'hc7)
		prog_u.read_byte(TPO_OFS_BANK2, rv);
		`CHK(rv, 8'hef)
		prog_u.read_byte(8'hc8, rv);
		`CHK(rv, 8'h00)
		prog_u.read_byte(TPO_OFS_STATUS, rv);
		`CHK(rv, 8'h0f)
		// Banks written after the decode must not reach the settings
		`CHK(tfrac, 8'h48)
		`CHK(pmode, 2'h0)
		`CHK(two_wire, 1'b0)
	endtask : t_regs

	task automatic samples(input int n, input logic [15:0] a, input logic [15:0] c);
		@(posedge clk_in);
		sample_valid <= 1'b1;
		long_term_average <= a;
		cs <= c;
		repeat (n) @(posedge clk_in);
		sample_valid <= 1'b0;
		#1;
	endtask : samples

	task automatic t_prox();
		samples(5, 16'd1000, 16'd996);
		samples(1, 16'd1000, 16'd997);
		samples(5, 16'd1000, 16'd996);
		`CHK(ppin, 1'b1)
		samples(1, 16'd1000, 16'd996);
		`CHK(ppin, 1'b0)
		`CHK(tpin, 1'b1)
		samples(1, 16'd1000, 16'd1010);
		`CHK(ppin, 1'b1)
	endtask : t_prox

	task automatic t_touch();
		int thr;
		thr = (1000 * 72) / 256;
		samples(3, 16'd1000, 16'(1000 - thr + 1));
		`CHK(tpin, 1'b1)
		samples(2, 16'd1000, 16'(1000 - thr));
		`CHK(tpin, 1'b1)
		samples(1, 16'd1000, 16'(1000 - thr));
		`CHK(tpin, 1'b0)
		samples(1, 16'd1000, 16'd1000);
		`CHK(tpin, 1'b1)
	endtask : t_touch

	task automatic t_reset_again();
		do_reset();
		wait_loaded();
		prog_u.read_byte(TPO_OFS_BANK0, rv);
		`CHK(rv, 8'h00)
		prog_u.write_byte(TPO_OFS_BANK0, 8'h11);
		prog_u.read_byte(TPO_OFS_BANK0, rv);
		`CHK(rv, 8'h11)
		`CHK(tfrac, 8'h48)
	endtask : t_reset_again

	// Active high, latching proximity, toggling touch, two-wire streaming
	task automatic t_options();
		program_banks(8'hed, 8'h46, 8'hea);
		`CHK(tpin, 1'b0)
		`CHK(ppin, 1'b0)
		`CHK(tfrac, 8'h30)
		`CHK(proximity_threshold_select, 5'h02)
		`CHK(hvalid, 1'b1)
		`CHK(hcode, 2'h1)
		`CHK(halt_s, 8'h28)
		`CHK(base, 9'h12c)
		`CHK(two_wire, 1'b1)
		`CHK(freq, 10'h0fa)
		`CHK(stream_en, 1'b1)
		`CHK(target, 11'h200)
		`CHK(partial, 1'b0)
		`CHK(pmode, 2'h2)
		`CHK(scan, 10'h100)
		samples(6, 16'd1000, 16'd998);
		`CHK(ppin, 1'b1)
		samples(1, 16'd1000, 16'd1000);
		`CHK(ppin, 1'b1)
		repeat (20) @(posedge clk_in);
		#1;
		`CHK(ppin, 1'b0)
		samples(3, 16'd1000, 16'd800);
		`CHK(tpin, 1'b1)
		samples(1, 16'd1000, 16'd1000);
		`CHK(tpin, 1'b1)
		samples(3, 16'd1000, 16'd800);
		`CHK(tpin, 1'b0)
	endtask : t_options

	// Partial tuning hides bank 1; full tuning halt codes 3 (long) and 2 (none)
	task automatic t_halt_modes();
		program_banks(8'h00, 8'hff, 8'h07);
		`CHK(hvalid, 1'b0)
		`CHK(hcode, 2'h0)
		`CHK(halt_s, 8'h00)
		`CHK(base, 9'h000)
		`CHK(partial, 1'b1)
		`CHK(pmode, 2'h3)
		`CHK(scan, 10'h200)
		program_banks(8'h00, 8'hc5, 8'h00);
		`CHK(hvalid, 1'b1)
		`CHK(hcode, 2'h3)
		`CHK(halt_s, 8'h28)
		`CHK(base, 9'h0fa)
		program_banks(8'h00, 8'h87, 8'h00);
		`CHK(hcode, 2'h2)
		`CHK(halt_s, 8'h00)
		`CHK(base, 9'h1f4)
	endtask : t_halt_modes

	initial begin
		#200000;
		fail_count++;
		tally_and_finish();
	end

	initial begin
		do_reset();
		wait_loaded();
		t_defaults();
		t_regs();
		t_prox();
		t_touch();
		t_reset_again();
		t_options();
		t_halt_modes();
		tally_and_finish();
	end
endmodule : tpo_option_decoder_tb_top
`default_nettype wire
